// File: hw/tcmev_access_check.sv
`timescale 1ns/1ns
`include "tcmev_map.svh"

module tcmev_access_check (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic acc_full_i,
    input wire logic [`TCMEV_ADDR_W-1:0] acc_addr_i,
    input wire logic [`TCMEV_ADDR_W:0] alloc_size_i,
    input wire logic ecc_on_i,
    input wire logic rd_ecc_single_i,
    input wire logic rd_ecc_multi_i,
    input wire tcmev_pkg::tcmev_watch_t watch_i,
    output tcmev_pkg::tcmev_ev_t event_o
);
    tcmev_pkg::tcmev_ev_t event_reg;
    tcmev_pkg::tcmev_ev_t event_next;

    always_comb begin
        event_next = '0;
        if (acc_valid_i) begin
            event_next[`TCMEV_EV_RANGE] = ({1'b0, acc_addr_i} >= alloc_size_i);
            event_next[`TCMEV_EV_WATCH] =
                (acc_addr_i == watch_i[`TCMEV_WATCH_ADDR_MSB:0]) &&
                (acc_write_i == watch_i[`TCMEV_WATCH_SEL_BIT]);
            if (!acc_write_i) begin
                event_next[`TCMEV_EV_ECCM] = rd_ecc_multi_i;
                event_next[`TCMEV_EV_ECC1] = rd_ecc_single_i && !rd_ecc_multi_i;
            end
            event_next[`TCMEV_EV_PART] = acc_write_i && !acc_full_i && ecc_on_i;
        end
    end

    // Events are re-timed here so the flag logic never sees raw datapath glitches
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_reg <= '0;
        end else begin
            event_reg <= event_next;
        end
    end

    assign event_o = event_reg;

    a_range_event: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        acc_valid_i && ({1'b0, acc_addr_i} >= alloc_size_i) |=> event_o[`TCMEV_EV_RANGE]
    ) else $error("out of range access not flagged");

    a_partial_event: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        event_o[`TCMEV_EV_PART] == ($past(acc_valid_i) && $past(acc_write_i) &&
                                    !$past(acc_full_i) && $past(ecc_on_i))
    ) else $error("partial write event mismatch");

    a_ecc_read_only: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (event_o[`TCMEV_EV_ECC1] || event_o[`TCMEV_EV_ECCM]) |->
            $past(acc_valid_i) && !$past(acc_write_i)
    ) else $error("ECC event without read");

    a_ecc_one_kind: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !(event_o[`TCMEV_EV_ECC1] && event_o[`TCMEV_EV_ECCM])
    ) else $error("single and multi ECC together");

    a_watch_type: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        event_o[`TCMEV_EV_WATCH] |->
            $past(acc_write_i) == $past(watch_i[`TCMEV_WATCH_SEL_BIT])
    ) else $error("watch hit with wrong access type");
endmodule

// File: hw/tcmev_event_unit.sv
`timescale 1ns/1ns
`include "tcmev_map.svh"

// How it works
// - Any access outside a memory's allocated size raises an out-of-range event.
// - Read ECC errors are reported as separate single and multiple error events.
// - A narrower-than-word write with ECC on raises a partial-write event.
// - Each memory type has a signal enable for its out-of-range interrupt.
// - Each memory type has a signal enable for its watch-address interrupt.
// - Each memory type has separate signal enables for single and multi ECC.
// - Each memory type has a signal enable for its partial-write interrupt.
// - All enabled flags are ORed into one interrupt request.
// - A flag exists per event kind and per memory, four memories.
// - Out-of-range event sets the flag of the affected memory.
// - Matching watch address and access type sets the watch-hit flag.
// - Single or multiple ECC flag set by the kind of error.
// - Partial write with ECC on sets the partial-write flag.
// - Writing one clears a flag; writing zero leaves it.
// - A flag sets only when its flag enable bit is set.
// - Per-memory flag enables exist for out-of-range and watch-hit.
// - Per-memory flag enables exist for single and multi ECC.
// - Per-memory flag enable exists for partial write.
// - Each memory type has a watch register: address plus access type.
// - Watch address is 16 bits inside that memory's own space.
// - Access type 0 watches reads, 1 watches writes.
// - Watch hit needs both address and access type to match.
// - Registers sit on the peripheral register port, separate from datapath.
module tcmev_event_unit (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_sel_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [`TCMEV_NUM_MEM-1:0] acc_valid_i,
    input wire logic [`TCMEV_NUM_MEM-1:0] acc_write_i,
    input wire logic [`TCMEV_NUM_MEM-1:0] acc_full_i,
    input wire logic [`TCMEV_NUM_MEM*`TCMEV_ADDR_W-1:0] acc_addr_i,
    input wire logic [`TCMEV_NUM_MEM*(`TCMEV_ADDR_W+1)-1:0] alloc_size_i,
    input wire logic [`TCMEV_NUM_MEM-1:0] ecc_on_i,
    input wire logic [`TCMEV_NUM_MEM-1:0] rd_ecc_single_i,
    input wire logic [`TCMEV_NUM_MEM-1:0] rd_ecc_multi_i,
    output logic irq_o
);
    tcmev_pkg::tcmev_sig_t irq_signal_enable_reg;
    tcmev_pkg::tcmev_sig_t irq_signal_enable_next;
    tcmev_pkg::tcmev_flags_t irq_event_flags_reg;
    tcmev_pkg::tcmev_flags_t irq_event_flags_next;
    tcmev_pkg::tcmev_flags_t irq_flag_enable_reg;
    tcmev_pkg::tcmev_flags_t irq_flag_enable_next;
    tcmev_pkg::tcmev_watch_t onchip_ram_watch_address_reg;
    tcmev_pkg::tcmev_watch_t onchip_ram_watch_address_next;
    tcmev_pkg::tcmev_watch_t data_tcm_watch_address_reg;
    tcmev_pkg::tcmev_watch_t data_tcm_watch_address_next;
    tcmev_pkg::tcmev_watch_t instr_tcm_watch_address_reg;
    tcmev_pkg::tcmev_watch_t instr_tcm_watch_address_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    tcmev_pkg::tcmev_ev_t mem_event [`TCMEV_NUM_MEM];
    tcmev_pkg::tcmev_watch_t mem_watch [`TCMEV_NUM_MEM];
    tcmev_pkg::tcmev_flags_t flag_set;
    tcmev_pkg::tcmev_flags_t sig_mask;

    logic wr_any;
    logic wr_sig_en;
    logic wr_flags;
    logic wr_flag_en;
    logic wr_ocram_watch;
    logic wr_data_watch;
    logic wr_instr_watch;

    assign wr_any = reg_sel_i && reg_write_i;
    assign wr_sig_en = wr_any && (reg_addr_i == `TCMEV_OFS_SIG_EN);
    assign wr_flags = wr_any && (reg_addr_i == `TCMEV_OFS_FLAGS);
    assign wr_flag_en = wr_any && (reg_addr_i == `TCMEV_OFS_FLAG_EN);
    assign wr_ocram_watch = wr_any && (reg_addr_i == `TCMEV_OFS_OCRAM_WATCH);
    assign wr_data_watch = wr_any && (reg_addr_i == `TCMEV_OFS_DATA_WATCH);
    assign wr_instr_watch = wr_any && (reg_addr_i == `TCMEV_OFS_INSTR_WATCH);

    // both data ports share the one data watch register
    assign mem_watch[`TCMEV_MEM_OCRAM] = onchip_ram_watch_address_reg;
    assign mem_watch[`TCMEV_MEM_D0] = data_tcm_watch_address_reg;
    assign mem_watch[`TCMEV_MEM_D1] = data_tcm_watch_address_reg;
    assign mem_watch[`TCMEV_MEM_INSTR] = instr_tcm_watch_address_reg;

    genvar m;
    genvar e;
    generate
        for (m = 0; m < `TCMEV_NUM_MEM; m = m + 1) begin : g_mem
            localparam int TYPE_IDX = (m == `TCMEV_MEM_OCRAM) ? `TCMEV_TYPE_OCRAM :
                                      (m == `TCMEV_MEM_INSTR) ? `TCMEV_TYPE_INSTR :
                                      `TCMEV_TYPE_DATA;

            tcmev_access_check u_check (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .acc_valid_i(acc_valid_i[m]),
                .acc_write_i(acc_write_i[m]),
                .acc_full_i(acc_full_i[m]),
                .acc_addr_i(acc_addr_i[m*`TCMEV_ADDR_W +: `TCMEV_ADDR_W]),
                .alloc_size_i(alloc_size_i[m*(`TCMEV_ADDR_W+1) +: (`TCMEV_ADDR_W+1)]),
                .ecc_on_i(ecc_on_i[m]),
                .rd_ecc_single_i(rd_ecc_single_i[m]),
                .rd_ecc_multi_i(rd_ecc_multi_i[m]),
                .watch_i(mem_watch[m]),
                .event_o(mem_event[m])
            );

            for (e = 0; e < `TCMEV_NUM_EV; e = e + 1) begin : g_ev
                assign flag_set[e*`TCMEV_NUM_MEM+m] =
                    mem_event[m][e] && irq_flag_enable_reg[e*`TCMEV_NUM_MEM+m];
                assign sig_mask[e*`TCMEV_NUM_MEM+m] =
                    irq_signal_enable_reg[e*`TCMEV_NUM_TYPE+TYPE_IDX];
            end
        end
    endgenerate

    always_comb begin
        irq_signal_enable_next = irq_signal_enable_reg;
        irq_flag_enable_next = irq_flag_enable_reg;
        onchip_ram_watch_address_next = onchip_ram_watch_address_reg;
        data_tcm_watch_address_next = data_tcm_watch_address_reg;
        instr_tcm_watch_address_next = instr_tcm_watch_address_reg;
        if (wr_sig_en) begin
            irq_signal_enable_next = reg_wdata_i[`TCMEV_SIG_W-1:0];
        end
        if (wr_flag_en) begin
            irq_flag_enable_next = reg_wdata_i[`TCMEV_FLAG_W-1:0];
        end
        if (wr_ocram_watch) begin
            onchip_ram_watch_address_next = reg_wdata_i[`TCMEV_WATCH_W-1:0];
        end
        if (wr_data_watch) begin
            data_tcm_watch_address_next = reg_wdata_i[`TCMEV_WATCH_W-1:0];
        end
        if (wr_instr_watch) begin
            instr_tcm_watch_address_next = reg_wdata_i[`TCMEV_WATCH_W-1:0];
        end
    end

    always_comb begin
        irq_event_flags_next = irq_event_flags_reg;
        if (wr_flags) begin
            irq_event_flags_next = irq_event_flags_next & ~reg_wdata_i[`TCMEV_FLAG_W-1:0];
        end
        // set after clear, so a set wins
        irq_event_flags_next = irq_event_flags_next | flag_set;
    end

    always_comb begin
        irq_next = |(irq_event_flags_reg & sig_mask);
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_sel_i && !reg_write_i) begin
            case (reg_addr_i)
                `TCMEV_OFS_SIG_EN: begin
                    rdata_next = {{(32-`TCMEV_SIG_W){1'b0}}, irq_signal_enable_reg};
                end
                `TCMEV_OFS_FLAGS: begin
                    rdata_next = {{(32-`TCMEV_FLAG_W){1'b0}}, irq_event_flags_reg};
                end
                `TCMEV_OFS_FLAG_EN: begin
                    rdata_next = {{(32-`TCMEV_FLAG_W){1'b0}}, irq_flag_enable_reg};
                end
                `TCMEV_OFS_OCRAM_WATCH: begin
                    rdata_next = {{(32-`TCMEV_WATCH_W){1'b0}}, onchip_ram_watch_address_reg};
                end
                `TCMEV_OFS_DATA_WATCH: begin
                    rdata_next = {{(32-`TCMEV_WATCH_W){1'b0}}, data_tcm_watch_address_reg};
                end
                `TCMEV_OFS_INSTR_WATCH: begin
                    rdata_next = {{(32-`TCMEV_WATCH_W){1'b0}}, instr_tcm_watch_address_reg};
                end
                default: begin
                    rdata_next = `TCMEV_RST_VAL;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_signal_enable_reg <= '0;
            irq_flag_enable_reg <= '0;
            irq_event_flags_reg <= '0;
            onchip_ram_watch_address_reg <= '0;
            data_tcm_watch_address_reg <= '0;
            instr_tcm_watch_address_reg <= '0;
            rdata_reg <= `TCMEV_RST_VAL;
            irq_reg <= 1'b0;
        end else begin
            irq_signal_enable_reg <= irq_signal_enable_next;
            irq_flag_enable_reg <= irq_flag_enable_next;
            irq_event_flags_reg <= irq_event_flags_next;
            onchip_ram_watch_address_reg <= onchip_ram_watch_address_next;
            data_tcm_watch_address_reg <= data_tcm_watch_address_next;
            instr_tcm_watch_address_reg <= instr_tcm_watch_address_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign irq_o = irq_reg;

    a_flag_needs_en: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 ((irq_event_flags_reg & ~$past(irq_event_flags_reg)) &
             ~$past(irq_flag_enable_reg)) == '0
    ) else $error("flag set while its enable was clear");

    a_w1c_clears: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_flags |=> (irq_event_flags_reg & $past(reg_wdata_i[`TCMEV_FLAG_W-1:0]) &
                      ~$past(flag_set)) == '0
    ) else $error("write one did not clear flag");

    a_w0_keeps: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_flags |=> ((~irq_event_flags_reg) & $past(irq_event_flags_reg) &
                      ~$past(reg_wdata_i[`TCMEV_FLAG_W-1:0])) == '0
    ) else $error("write zero changed a flag");

    a_set_wins: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (flag_set != '0) |=> ((irq_event_flags_reg & $past(flag_set)) == $past(flag_set))
    ) else $error("enabled event lost");

    a_irq_level: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 irq_o == |($past(irq_event_flags_reg) & $past(sig_mask))
    ) else $error("interrupt does not follow enabled flags");

    a_irq_drops: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ((irq_event_flags_reg & sig_mask) == '0) [*2] |-> !irq_o
    ) else $error("interrupt held with no enabled flag");

    a_watch_reads: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        acc_valid_i[`TCMEV_MEM_INSTR] && !acc_write_i[`TCMEV_MEM_INSTR] &&
        !instr_tcm_watch_address_reg[`TCMEV_WATCH_SEL_BIT] &&
        (acc_addr_i[`TCMEV_MEM_INSTR*`TCMEV_ADDR_W +: `TCMEV_ADDR_W] ==
         instr_tcm_watch_address_reg[`TCMEV_WATCH_ADDR_MSB:0]) &&
        irq_flag_enable_reg[`TCMEV_EV_WATCH*`TCMEV_NUM_MEM+`TCMEV_MEM_INSTR]
        ##1 irq_flag_enable_reg[`TCMEV_EV_WATCH*`TCMEV_NUM_MEM+`TCMEV_MEM_INSTR]
        |=> irq_event_flags_reg[`TCMEV_EV_WATCH*`TCMEV_NUM_MEM+`TCMEV_MEM_INSTR]
    ) else $error("read watch hit not recorded");

    a_range_path: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        acc_valid_i[`TCMEV_MEM_OCRAM] &&
        ({1'b0, acc_addr_i[`TCMEV_ADDR_W-1:0]} >= alloc_size_i[`TCMEV_ADDR_W:0]) &&
        irq_flag_enable_reg[`TCMEV_EV_RANGE*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
        ##1 irq_flag_enable_reg[`TCMEV_EV_RANGE*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
        |=> irq_event_flags_reg[`TCMEV_EV_RANGE*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
    ) else $error("out of range flag not set two cycles after access");

    a_data_shared: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        sig_mask[`TCMEV_EV_ECCM*`TCMEV_NUM_MEM+`TCMEV_MEM_D1] ==
        irq_signal_enable_reg[`TCMEV_EV_ECCM*`TCMEV_NUM_TYPE+`TCMEV_TYPE_DATA]
    ) else $error("data port uses wrong signal enable");

    a_rdata_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !(reg_sel_i && !reg_write_i) |=> $stable(reg_rdata_o)
    ) else $error("read data changed without a read");

    a_hole_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        reg_sel_i && !reg_write_i && (reg_addr_i > `TCMEV_OFS_INSTR_WATCH) |=>
            reg_rdata_o == '0
    ) else $error("unmapped offset read not zero");

    a_flag_read: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        reg_sel_i && !reg_write_i && (reg_addr_i == `TCMEV_OFS_FLAGS) |=>
            reg_rdata_o[`TCMEV_FLAG_W-1:0] == $past(irq_event_flags_reg)
    ) else $error("flag readback mismatch");

    a_sig_en_store: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_sig_en |=> irq_signal_enable_reg == $past(reg_wdata_i[`TCMEV_SIG_W-1:0])
    ) else $error("signal enable write lost");

    a_flag_en_store: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_flag_en |=> irq_flag_enable_reg == $past(reg_wdata_i[`TCMEV_FLAG_W-1:0])
    ) else $error("flag enable write lost");

    a_instr_watch_store: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_instr_watch |=>
            instr_tcm_watch_address_reg == $past(reg_wdata_i[`TCMEV_WATCH_W-1:0])
    ) else $error("instruction watch write lost");

    a_data_watch_store: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_data_watch |=>
            data_tcm_watch_address_reg == $past(reg_wdata_i[`TCMEV_WATCH_W-1:0])
    ) else $error("data watch write lost");

    a_ram_watch_store: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_ocram_watch |=>
            onchip_ram_watch_address_reg == $past(reg_wdata_i[`TCMEV_WATCH_W-1:0])
    ) else $error("on-chip RAM watch write lost");

    a_flag_sticky: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !wr_flags |=> ($past(irq_event_flags_reg) & ~irq_event_flags_reg) == '0
    ) else $error("flag dropped without a clear");

    a_part_path: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        acc_valid_i[`TCMEV_MEM_D0] && acc_write_i[`TCMEV_MEM_D0] &&
        !acc_full_i[`TCMEV_MEM_D0] && ecc_on_i[`TCMEV_MEM_D0] &&
        irq_flag_enable_reg[`TCMEV_EV_PART*`TCMEV_NUM_MEM+`TCMEV_MEM_D0]
        ##1 irq_flag_enable_reg[`TCMEV_EV_PART*`TCMEV_NUM_MEM+`TCMEV_MEM_D0]
        |=> irq_event_flags_reg[`TCMEV_EV_PART*`TCMEV_NUM_MEM+`TCMEV_MEM_D0]
    ) else $error("partial write flag not set");

    a_multi_path: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        acc_valid_i[`TCMEV_MEM_OCRAM] && !acc_write_i[`TCMEV_MEM_OCRAM] &&
        rd_ecc_multi_i[`TCMEV_MEM_OCRAM] &&
        irq_flag_enable_reg[`TCMEV_EV_ECCM*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
        ##1 irq_flag_enable_reg[`TCMEV_EV_ECCM*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
        |=> irq_event_flags_reg[`TCMEV_EV_ECCM*`TCMEV_NUM_MEM+`TCMEV_MEM_OCRAM]
    ) else $error("multi ECC flag not set");
endmodule

// File: include/tcmev_map.svh
`ifndef TCMEV_MAP_SVH
`define TCMEV_MAP_SVH

// Register byte offsets on the peripheral register port
`define TCMEV_OFS_SIG_EN 8'h00
`define TCMEV_OFS_FLAGS 8'h04
`define TCMEV_OFS_FLAG_EN 8'h08
`define TCMEV_OFS_OCRAM_WATCH 8'h0C
`define TCMEV_OFS_DATA_WATCH 8'h10
`define TCMEV_OFS_INSTR_WATCH 8'h14

// Reset value of every register
`define TCMEV_RST_VAL 32'h0000_0000

// Sizes
`define TCMEV_NUM_MEM 4
`define TCMEV_NUM_TYPE 3
`define TCMEV_NUM_EV 5
`define TCMEV_FLAG_W 20
`define TCMEV_SIG_W 15
`define TCMEV_ADDR_W 16

// Event positions inside an event vector
`define TCMEV_EV_RANGE 0
`define TCMEV_EV_WATCH 1
`define TCMEV_EV_ECC1 2
`define TCMEV_EV_ECCM 3
`define TCMEV_EV_PART 4

// Memory positions: flag bit = event * 4 + memory
`define TCMEV_MEM_OCRAM 0
`define TCMEV_MEM_D0 1
`define TCMEV_MEM_D1 2
`define TCMEV_MEM_INSTR 3

// Memory type positions: signal enable bit = event * 3 + type
`define TCMEV_TYPE_OCRAM 0
`define TCMEV_TYPE_DATA 1
`define TCMEV_TYPE_INSTR 2

// Watch register fields
`define TCMEV_WATCH_ADDR_MSB 15
`define TCMEV_WATCH_SEL_BIT 16
`define TCMEV_WATCH_W 17

`endif

// File: include/tcmev_pkg.sv
`include "tcmev_map.svh"

package tcmev_pkg;
    typedef logic [`TCMEV_NUM_EV-1:0] tcmev_ev_t;
    typedef logic [`TCMEV_FLAG_W-1:0] tcmev_flags_t;
    typedef logic [`TCMEV_SIG_W-1:0] tcmev_sig_t;
    typedef logic [`TCMEV_WATCH_W-1:0] tcmev_watch_t;
endpackage

// File: tb/tcmev_mem_model.sv
`timescale 1ns/1ns
`include "tcmev_map.svh"

// Memory datapath side: raises one access per call, idles with scrambled lines
module tcmev_mem_model #(
    parameter logic [16:0] ALLOC_SIZE = 17'h0_1000
) (
    input wire logic core_clk_i,
    output logic [`TCMEV_NUM_MEM-1:0] acc_valid_o,
    output logic [`TCMEV_NUM_MEM-1:0] acc_write_o,
    output logic [`TCMEV_NUM_MEM-1:0] acc_full_o,
    output logic [`TCMEV_NUM_MEM*`TCMEV_ADDR_W-1:0] acc_addr_o,
    output logic [`TCMEV_NUM_MEM*(`TCMEV_ADDR_W+1)-1:0] alloc_size_o,
    output logic [`TCMEV_NUM_MEM-1:0] ecc_on_o,
    output logic [`TCMEV_NUM_MEM-1:0] rd_ecc_single_o,
    output logic [`TCMEV_NUM_MEM-1:0] rd_ecc_multi_o
);
    assign alloc_size_o = {`TCMEV_NUM_MEM{ALLOC_SIZE}};

    initial begin
        acc_valid_o = '0;
        acc_write_o = '0;
        acc_full_o = '1;
        acc_addr_o = '0;
        ecc_on_o = '1;
        rd_ecc_single_o = '0;
        rd_ecc_multi_o = '0;
    end

    task automatic set_ecc(input logic [`TCMEV_NUM_MEM-1:0] on);
        @(negedge core_clk_i);
        ecc_on_o = on;
    endtask

    // One-cycle strobe; qualifiers are inverted afterwards so stale values never look valid
    task automatic access(input int m, input logic wr, input logic full,
                          input logic [15:0] addr, input logic es, input logic em);
        @(negedge core_clk_i);
        acc_valid_o[m] = 1'b1;
        acc_write_o[m] = wr;
        acc_full_o[m] = full;
        acc_addr_o[m*16 +: 16] = addr;
        rd_ecc_single_o[m] = es;
        rd_ecc_multi_o[m] = em;
        @(negedge core_clk_i);
        acc_valid_o = '0;
        acc_write_o = ~acc_write_o;
        acc_full_o = ~acc_full_o;
        acc_addr_o = ~acc_addr_o;
        rd_ecc_single_o = ~rd_ecc_single_o;
        rd_ecc_multi_o = ~rd_ecc_multi_o;
    endtask
endmodule

// File: tb/test_tcm_ram_error_event_unit.sv
`timescale 1ns/1ns
`include "tcmev_map.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module test_tcm_ram_error_event_unit;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_sel = 1'b0;
    logic reg_write = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic irq;
    logic [3:0] acc_valid, acc_write, acc_full, ecc_on, ecc_s, ecc_m;
    logic [63:0] acc_addr;
    logic [67:0] alloc_size;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic [31:0] fb;
    logic [31:0] sb;
    int typ;

    always #50 core_clk = ~core_clk;

    tcmev_event_unit tcmev_event_unit_i (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .reg_sel_i(reg_sel), .reg_write_i(reg_write), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .acc_valid_i(acc_valid),
        .acc_write_i(acc_write), .acc_full_i(acc_full), .acc_addr_i(acc_addr),
        .alloc_size_i(alloc_size), .ecc_on_i(ecc_on), .rd_ecc_single_i(ecc_s),
        .rd_ecc_multi_i(ecc_m), .irq_o(irq));

    tcmev_mem_model tcmev_mem_model_i (.core_clk_i(core_clk), .acc_valid_o(acc_valid),
        .acc_write_o(acc_write), .acc_full_o(acc_full), .acc_addr_o(acc_addr),
        .alloc_size_o(alloc_size), .ecc_on_o(ecc_on), .rd_ecc_single_o(ecc_s),
        .rd_ecc_multi_o(ecc_m));

    task automatic reg_xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
        @(negedge core_clk);
        reg_sel = 1'b1;
        reg_write = wr;
        reg_addr = a;
        reg_wdata = v;
        @(negedge core_clk);
        reg_sel = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        reg_xfer(1'b1, a, v);
    endtask

    // Read data holds until the next read, so sampling one cycle late is safe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        reg_xfer(1'b0, a, 32'h0000_0000);
        @(negedge core_clk);
        v = reg_rdata;
    endtask

    // Each event kind gets its own access shape so no other kind fires by accident
    task automatic fire(input int m, input int ev);
        case (ev)
            0: tcmev_mem_model_i.access(m, 1'b0, 1'b1, 16'h1000, 1'b0, 1'b0);
            1: tcmev_mem_model_i.access(m, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b0);
            2: tcmev_mem_model_i.access(m, 1'b0, 1'b1, 16'h0010, 1'b1, 1'b0);
            3: tcmev_mem_model_i.access(m, 1'b0, 1'b1, 16'h0010, 1'b1, 1'b1);
            default: tcmev_mem_model_i.access(m, 1'b1, 1'b0, 16'h0020, 1'b0, 1'b0);
        endcase
        repeat (4) @(negedge core_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        // Reset values and the unmapped hole
        for (int a = 0; a <= 24; a += 4) begin
            reg_rd(a[7:0], d);
            `CHK(d, `TCMEV_RST_VAL)
        end
        `CHK(irq, 1'b0)
        reg_wr(8'h18, 32'hFFFF_FFFF);
        reg_rd(8'h18, d);
        `CHK(d, 32'h0000_0000)
        reg_wr(`TCMEV_OFS_FLAGS, 32'hFFFF_FFFF);
        reg_rd(`TCMEV_OFS_FLAGS, d);
        `CHK(d, 32'h0000_0000)
        reg_wr(`TCMEV_OFS_SIG_EN, 32'hFFFF_FFFF);
        reg_rd(`TCMEV_OFS_SIG_EN, d);
        `CHK(d, 32'h0000_7FFF)
        reg_wr(`TCMEV_OFS_FLAG_EN, 32'hFFFF_FFFF);
        reg_rd(`TCMEV_OFS_FLAG_EN, d);
        `CHK(d, 32'h000F_FFFF)
        for (int t = 0; t < 3; t++) begin
            reg_wr(`TCMEV_OFS_OCRAM_WATCH + 8'(4 * t), 32'hFFFF_FFFF);
            reg_rd(`TCMEV_OFS_OCRAM_WATCH + 8'(4 * t), d);
            `CHK(d, 32'h0001_FFFF)
            reg_wr(`TCMEV_OFS_OCRAM_WATCH + 8'(4 * t), 32'h0000_0123);
        end
        $display("test registers done");

        // Every event kind on every memory: set, gate, hold, clear, drop
        for (int ev = 0; ev < 5; ev++) begin
            for (int m = 0; m < 4; m++) begin
                typ = (m == 0) ? 0 : ((m == 3) ? 2 : 1);
                fb = 32'h0000_0001 << (ev * 4 + m);
                sb = 32'h0000_0001 << (ev * 3 + typ);
                reg_wr(`TCMEV_OFS_FLAG_EN, 32'h000F_FFFF);
                reg_wr(`TCMEV_OFS_SIG_EN, sb);
                fire(m, ev);
                reg_rd(`TCMEV_OFS_FLAGS, d);
                `CHK(d, fb)
                `CHK(irq, 1'b1)
                reg_wr(`TCMEV_OFS_SIG_EN, ~sb & 32'h0000_7FFF);
                repeat (2) @(negedge core_clk);
                `CHK(irq, 1'b0)
                reg_wr(`TCMEV_OFS_SIG_EN, sb);
                reg_wr(`TCMEV_OFS_FLAGS, ~fb);
                reg_rd(`TCMEV_OFS_FLAGS, d);
                `CHK(d, fb)
                `CHK(irq, 1'b1)
                reg_wr(`TCMEV_OFS_FLAGS, fb);
                reg_rd(`TCMEV_OFS_FLAGS, d);
                `CHK(d, 32'h0000_0000)
                `CHK(irq, 1'b0)
                reg_wr(`TCMEV_OFS_FLAG_EN, ~fb & 32'h000F_FFFF);
                fire(m, ev);
                reg_rd(`TCMEV_OFS_FLAGS, d);
                `CHK(d, 32'h0000_0000)
                `CHK(irq, 1'b0)
            end
        end
        $display("test event matrix done");

        // Non-events: ECC off, full word, errors on writes, wrong access type
        reg_wr(`TCMEV_OFS_FLAG_EN, 32'h000F_FFFF);
        reg_wr(`TCMEV_OFS_SIG_EN, 32'h0000_0000);
        tcmev_mem_model_i.set_ecc(4'h0);
        tcmev_mem_model_i.access(1, 1'b1, 1'b0, 16'h0020, 1'b0, 1'b0);
        tcmev_mem_model_i.set_ecc(4'hF);
        tcmev_mem_model_i.access(1, 1'b1, 1'b1, 16'h0020, 1'b0, 1'b0);
        tcmev_mem_model_i.access(2, 1'b1, 1'b1, 16'h0010, 1'b1, 1'b1);
        tcmev_mem_model_i.access(3, 1'b1, 1'b1, 16'h0123, 1'b0, 1'b0);
        tcmev_mem_model_i.access(0, 1'b0, 1'b1, 16'h0124, 1'b0, 1'b0);
        tcmev_mem_model_i.access(0, 1'b0, 1'b1, 16'h0FFF, 1'b0, 1'b0);
        repeat (4) @(negedge core_clk);
        reg_rd(`TCMEV_OFS_FLAGS, d);
        `CHK(d, 32'h0000_0000)
        // Write-type watch on the data ports: writes hit, reads do not
        reg_wr(`TCMEV_OFS_DATA_WATCH, 32'h0001_0123);
        tcmev_mem_model_i.access(2, 1'b0, 1'b1, 16'h0123, 1'b0, 1'b0);
        tcmev_mem_model_i.access(2, 1'b1, 1'b1, 16'h0123, 1'b0, 1'b0);
        repeat (4) @(negedge core_clk);
        reg_rd(`TCMEV_OFS_FLAGS, d);
        `CHK(d, 32'h0000_0040)
        $display("test non-events done");
        give_verdict();
    end
endmodule
